// >>> src/flash_cmd_map.vh
// Purpose: Shared constants for the program region mode checker.
// Assumes: Word addressed flash bus, 16-bit command codes.
// Notes: Register offsets are byte addresses on the Avalon-MM slave.
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
// Register offsets
`define REG_BUS_ADDR 8'h00
`define REG_BUS_DATA 8'h04
`define REG_STATUS 8'h08
`define REG_READ_MODE 8'h0C
// Flash bus command codes
`define CMD_SINGLE 16'h0041
`define CMD_BUFFER 16'h00E9
`define CMD_FACTORY 16'h0080
`define CMD_CONFIRM 16'h00D0
`define CMD_ERASE 16'h0020
`define CMD_SUSPEND 16'h00B0
`define CMD_LOCK_SETUP 16'h0060
`define CMD_LOCK 16'h0001
`define CMD_CLR_STATUS 16'h0050
`define CMD_READ_ARRAY 16'h00FF
`define CMD_READ_STATUS 16'h0070
`define CMD_READ_DEVINFO 16'h0090
`define CMD_CFI_QUERY 16'h0098
`define WORD_ERASED 16'hFFFF
// Pending setup kinds
`define PEND_NONE 3'h0
`define PEND_SINGLE 3'h1
`define PEND_BUFFER 3'h2
`define PEND_FACTORY 3'h3
`define PEND_ERASE 3'h4
`define PEND_LOCK 3'h5
// Region states and read modes
`define RGN_ERASED 2'h0
`define RGN_CONTROL 2'h1
`define RGN_OBJECT 2'h2
`define RD_ARRAY 2'h0
`define RD_STATUS 2'h1
`define RD_DEVINFO 2'h2
`define RD_CFI 2'h3
// Address fields (word address)
`define HALF_BIT 3
`define REGION_LSB 9
`define REGION_W 8
`define BLOCK_LSB 17
`define PART_W 3
// Status word
`define STATUS_W 10
`define SB_SUSPENDED 6
`define SB_READY 7
`define MASK_LOCK 10'h002
`define MASK_VPP 10'h008
`define MASK_PE 10'h010
`define MASK_ERS 10'h020
`define MASK_OR 10'h100
`define MASK_CV 10'h200
`define MASK_ERR 10'h33A
`endif

// >>> src/program_region_mode_checker.v
// Purpose: Command side of a partitioned flash: read modes, region modes, program checks.
// Assumes: Flash bus write cycles are issued through the BUS_ADDR and BUS_DATA registers.
// Notes: Word count and buffer fill are not modelled; buffered programs write zeros.
// Behaviour
// - CFI query command puts the addressed partition in CFI read mode.
// - CFI mode holds until another read command or a program or erase starts.
// - CFI query to a busy partition switches mode; reads flagged invalid meanwhile.
// - CFI query is taken whatever the programming supply level.
// - Eight equal partitions of 256 KB blocks, count set by density.
// - Each block holds 256 regions of 1 KB.
// - Region mode fixed by first program; changes only after block erase.
// - Zeros only in lower half make a region control mode.
// - Control regions accept single, buffered and factory buffered programs.
// - Zero into upper half of control region aborts with error and violation.
// - A buffered zero in the upper half makes an erased region object mode.
// - Object regions take no further programs, buffered or single-word.
// - Further program to object region aborts with error and rewrite flags.
// - Single-word to upper half of erased region sets rewrite and violation.
// - Control region upper half: buffered sets error, violation; single sets all three.
// - Programming only clears bits; an all-ones word changes nothing.
// - One program at a time; programming allowed while erase is suspended.
// - Locked block or missing supply aborts program with matching error flags.
// - Ready flag low while programming, high again on completion.
`include "flash_cmd_map.vh"
module program_region_mode_checker #(
    parameter BLOCK_BITS = 6,
    parameter PROG_CYCLES = 100
) (
    input wire I_CLK,
    input wire I_RST_N,
    input wire [7:0] I_AVS_ADDRESS,
    input wire I_AVS_READ,
    input wire I_AVS_WRITE,
    input wire [31:0] I_AVS_WRITEDATA,
    output reg [31:0] O_AVS_READDATA,
    output reg O_AVS_WAITREQUEST,
    input wire I_VPP_VALID,
    output reg O_DEVICE_READY
);
    localparam ADDR_W = `BLOCK_LSB + BLOCK_BITS;
    localparam RAM_AW = BLOCK_BITS + `REGION_W;
    localparam NUM_PARTS = 1 << `PART_W;
    localparam S_IDLE = 5'b00001;
    localparam S_CHECK = 5'b00010;
    localparam S_PROG = 5'b00100;
    localparam S_ERASE = 5'b01000;
    localparam S_INIT = 5'b10000;
    localparam [31:0] PROG_LAST_W = PROG_CYCLES - 1;
    localparam [15:0] PROG_LAST = PROG_LAST_W[15:0];

    reg [ADDR_W-1:0] addr_reg;
    reg [4:0] state_reg, state_next;
    reg [2:0] pend_reg, pend_next;
    reg [ADDR_W-1:0] op_addr_reg, op_addr_next;
    reg op_single_reg, op_single_next;
    reg op_zero_reg, op_zero_next;
    reg [1:0] new_rgn_reg, new_rgn_next;
    reg [15:0] prog_cnt_reg, prog_cnt_next;
    reg erase_active_reg, erase_active_next;
    reg suspended_reg, suspended_next;
    reg [BLOCK_BITS-1:0] erase_blk_reg, erase_blk_next;
    reg [RAM_AW-1:0] sweep_reg, sweep_next;
    reg [(1<<BLOCK_BITS)-1:0] lock_reg, lock_next;
    reg [2*NUM_PARTS-1:0] part_mode_reg, part_mode_next;
    reg [`STATUS_W-1:0] flags_reg, set_vec, clr_vec;
    reg [`STATUS_W-1:0] status_word;
    reg [31:0] read_word;
    reg ram_we;
    reg [RAM_AW-1:0] ram_waddr;
    reg [1:0] ram_wdata;
    wire [1:0] ram_rdata;
    wire [`STATUS_W-1:0] chk_err;
    wire [1:0] chk_new;

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, action on the edge waitrequest is low
    wire req = I_AVS_READ | I_AVS_WRITE;
    wire wr_go = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
    wire bus_wr = wr_go && (I_AVS_ADDRESS == `REG_BUS_DATA);
    wire [15:0] cmd = I_AVS_WRITEDATA[15:0];

    wire [BLOCK_BITS-1:0] cur_blk = addr_reg[ADDR_W-1:`BLOCK_LSB];
    wire [`PART_W-1:0] cur_part = cur_blk[BLOCK_BITS-1 -: `PART_W];
    wire [BLOCK_BITS-1:0] op_blk = op_addr_reg[ADDR_W-1:`BLOCK_LSB];
    wire [`PART_W-1:0] op_part = op_blk[BLOCK_BITS-1 -: `PART_W];
    wire [`PART_W-1:0] erase_part = erase_blk_reg[BLOCK_BITS-1 -: `PART_W];
    wire [RAM_AW-1:0] cur_rgn = {cur_blk, addr_reg[`REGION_LSB +: `REGION_W]};
    wire [RAM_AW-1:0] op_rgn = {op_blk, op_addr_reg[`REGION_LSB +: `REGION_W]};
    wire prog_busy = (state_reg == S_CHECK) || (state_reg == S_PROG);
    wire is_prog_cmd = (cmd == `CMD_SINGLE) || (cmd == `CMD_BUFFER) || (cmd == `CMD_FACTORY);
    wire is_read_cmd = (cmd == `CMD_READ_ARRAY) || (cmd == `CMD_READ_STATUS) ||
                       (cmd == `CMD_READ_DEVINFO) || (cmd == `CMD_CFI_QUERY);

    // Reads in a busy partition are invalid
    wire data_valid = ~(prog_busy && (op_part == cur_part)) &
                      ~((state_reg == S_ERASE) && (erase_part == cur_part));

    region_state_ram #(
        .AW(RAM_AW)
    ) u_ram (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_we(ram_we),
        .i_waddr(ram_waddr),
        .i_wdata(ram_wdata),
        .i_raddr(cur_rgn),
        .o_rdata(ram_rdata)
    );

    region_mode_decide u_decide (
        .i_single(op_single_reg),
        .i_upper(op_addr_reg[`HALF_BIT]),
        .i_state(ram_rdata),
        .o_err(chk_err),
        .o_new_state(chk_new)
    );

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer and command decode
    always @* begin
        state_next = state_reg;
        pend_next = pend_reg;
        op_addr_next = op_addr_reg;
        op_single_next = op_single_reg;
        op_zero_next = op_zero_reg;
        new_rgn_next = new_rgn_reg;
        prog_cnt_next = prog_cnt_reg;
        erase_active_next = erase_active_reg;
        suspended_next = suspended_reg;
        erase_blk_next = erase_blk_reg;
        sweep_next = sweep_reg;
        lock_next = lock_reg;
        part_mode_next = part_mode_reg;
        set_vec = {`STATUS_W{1'b0}};
        clr_vec = {`STATUS_W{1'b0}};
        ram_we = 1'b0;
        ram_waddr = sweep_reg;
        ram_wdata = `RGN_ERASED;
        if (wr_go && (I_AVS_ADDRESS == `REG_STATUS)) begin
            clr_vec = `MASK_ERR;
        end
        case (state_reg)
            S_INIT: begin
                // Power-up sweep leaves every region erased
                ram_we = 1'b1;
                sweep_next = sweep_reg + 1'b1;
                if (&sweep_reg) begin
                    state_next = S_IDLE;
                end
            end
            S_CHECK: begin
                if (!I_VPP_VALID) begin
                    set_vec = `MASK_VPP | `MASK_PE;
                    state_next = S_IDLE;
                end else if (lock_reg[op_blk]) begin
                    set_vec = `MASK_LOCK | `MASK_PE;
                    state_next = S_IDLE;
                end else if (chk_err != {`STATUS_W{1'b0}}) begin
                    set_vec = chk_err;
                    state_next = S_IDLE;
                end else begin
                    clr_vec = clr_vec | `MASK_PE | `MASK_OR | `MASK_CV;
                    new_rgn_next = op_zero_reg ? chk_new : ram_rdata;
                    prog_cnt_next = 16'h0000;
                    state_next = S_PROG;
                end
            end
            S_PROG: begin
                if (!I_VPP_VALID) begin
                    set_vec = `MASK_VPP | `MASK_PE;
                    state_next = S_IDLE;
                end else if (prog_cnt_reg == PROG_LAST) begin
                    ram_we = 1'b1;
                    ram_waddr = op_rgn;
                    ram_wdata = new_rgn_reg;
                    state_next = S_IDLE;
                end else begin
                    prog_cnt_next = prog_cnt_reg + 1'b1;
                end
            end
            S_ERASE: begin
                if (!I_VPP_VALID) begin
                    set_vec = `MASK_VPP | `MASK_ERS;
                    erase_active_next = 1'b0;
                    state_next = S_IDLE;
                end else begin
                    ram_we = 1'b1;
                    ram_waddr = {erase_blk_reg, sweep_reg[`REGION_W-1:0]};
                    sweep_next = sweep_reg + 1'b1;
                    if (&sweep_reg[`REGION_W-1:0]) begin
                        erase_active_next = 1'b0;
                        state_next = S_IDLE;
                    end
                end
            end
            default: begin
            end
        endcase
        if (bus_wr && (state_reg != S_INIT)) begin
            if (pend_reg != `PEND_NONE) begin
                pend_next = `PEND_NONE;
                if ((pend_reg == `PEND_SINGLE) ||
                    (((pend_reg == `PEND_BUFFER) || (pend_reg == `PEND_FACTORY)) &&
                     (cmd == `CMD_CONFIRM))) begin
                    state_next = S_CHECK;
                    op_addr_next = addr_reg;
                    op_single_next = (pend_reg == `PEND_SINGLE);
                    op_zero_next = (pend_reg != `PEND_SINGLE) || (cmd != `WORD_ERASED);
                end else if ((pend_reg == `PEND_ERASE) && (cmd == `CMD_CONFIRM)) begin
                    if (!I_VPP_VALID) begin
                        set_vec = set_vec | `MASK_VPP | `MASK_ERS;
                    end else if (lock_reg[cur_blk]) begin
                        set_vec = set_vec | `MASK_LOCK | `MASK_ERS;
                    end else begin
                        erase_active_next = 1'b1;
                        erase_blk_next = cur_blk;
                        sweep_next = {RAM_AW{1'b0}};
                        state_next = S_ERASE;
                    end
                end else if ((pend_reg == `PEND_LOCK) &&
                             ((cmd == `CMD_LOCK) || (cmd == `CMD_CONFIRM))) begin
                    lock_next[cur_blk] = (cmd == `CMD_LOCK);
                end else begin
                    // Bad second cycle is a sequence error
                    set_vec = set_vec | `MASK_PE | `MASK_ERS;
                end
            end else if (is_read_cmd) begin
                if (cmd == `CMD_CFI_QUERY) begin
                    part_mode_next[{cur_part, 1'b0} +: 2] = `RD_CFI;
                end else if (cmd == `CMD_READ_DEVINFO) begin
                    part_mode_next[{cur_part, 1'b0} +: 2] = `RD_DEVINFO;
                end else if (cmd == `CMD_READ_STATUS) begin
                    part_mode_next[{cur_part, 1'b0} +: 2] = `RD_STATUS;
                end else begin
                    part_mode_next[{cur_part, 1'b0} +: 2] = `RD_ARRAY;
                end
            end else if (cmd == `CMD_CLR_STATUS) begin
                clr_vec = `MASK_ERR;
            end else if ((state_reg == S_IDLE) && is_prog_cmd) begin
                pend_next = (cmd == `CMD_SINGLE) ? `PEND_SINGLE :
                            (cmd == `CMD_BUFFER) ? `PEND_BUFFER : `PEND_FACTORY;
                part_mode_next[{cur_part, 1'b0} +: 2] = `RD_STATUS;
            end else if ((state_reg == S_IDLE) && !erase_active_reg && (cmd == `CMD_ERASE)) begin
                pend_next = `PEND_ERASE;
                part_mode_next[{cur_part, 1'b0} +: 2] = `RD_STATUS;
            end else if ((state_reg == S_IDLE) && (cmd == `CMD_LOCK_SETUP)) begin
                pend_next = `PEND_LOCK;
            end else if ((state_reg == S_ERASE) && erase_active_next &&
                         (cmd == `CMD_SUSPEND)) begin
                suspended_next = 1'b1;
                state_next = S_IDLE;
            end else if ((state_reg == S_IDLE) && suspended_reg && (cmd == `CMD_CONFIRM)) begin
                suspended_next = 1'b0;
                state_next = S_ERASE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg <= S_INIT;
            pend_reg <= `PEND_NONE;
            op_addr_reg <= {ADDR_W{1'b0}};
            op_single_reg <= 1'b0;
            op_zero_reg <= 1'b0;
            new_rgn_reg <= `RGN_ERASED;
            prog_cnt_reg <= 16'h0000;
            erase_active_reg <= 1'b0;
            suspended_reg <= 1'b0;
            erase_blk_reg <= {BLOCK_BITS{1'b0}};
            sweep_reg <= {RAM_AW{1'b0}};
            lock_reg <= {(1<<BLOCK_BITS){1'b0}};
            part_mode_reg <= {NUM_PARTS{`RD_ARRAY}};
            flags_reg <= {`STATUS_W{1'b0}};
            addr_reg <= {ADDR_W{1'b0}};
            O_DEVICE_READY <= 1'b0;
        end else begin
            state_reg <= state_next;
            pend_reg <= pend_next;
            op_addr_reg <= op_addr_next;
            op_single_reg <= op_single_next;
            op_zero_reg <= op_zero_next;
            new_rgn_reg <= new_rgn_next;
            prog_cnt_reg <= prog_cnt_next;
            erase_active_reg <= erase_active_next;
            suspended_reg <= suspended_next;
            erase_blk_reg <= erase_blk_next;
            sweep_reg <= sweep_next;
            lock_reg <= lock_next;
            part_mode_reg <= part_mode_next;
            // Set beats clear in the same cycle
            flags_reg <= (flags_reg & ~clr_vec) | set_vec;
            if (wr_go && (I_AVS_ADDRESS == `REG_BUS_ADDR)) begin
                addr_reg <= I_AVS_WRITEDATA[ADDR_W-1:0];
            end
            O_DEVICE_READY <= (state_next == S_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    always @* begin
        status_word = flags_reg;
        status_word[`SB_READY] = O_DEVICE_READY;
        status_word[`SB_SUSPENDED] = suspended_reg;
        if (I_AVS_ADDRESS == `REG_BUS_ADDR) begin
            read_word = {{(32-ADDR_W){1'b0}}, addr_reg};
        end else if (I_AVS_ADDRESS == `REG_STATUS) begin
            read_word = {{(32-`STATUS_W){1'b0}}, status_word};
        end else if (I_AVS_ADDRESS == `REG_READ_MODE) begin
            read_word = {28'h0000000, lock_reg[cur_blk], data_valid,
                         part_mode_reg[{cur_part, 1'b0} +: 2]};
        end else begin
            read_word = 32'h00000000;
        end
    end

    // Waitrequest drops for exactly one cycle per request
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h00000000;
        end else begin
            O_AVS_WAITREQUEST <= ~(req & O_AVS_WAITREQUEST);
            if (I_AVS_READ && O_AVS_WAITREQUEST) begin
                O_AVS_READDATA <= read_word;
            end
        end
    end
endmodule // program_region_mode_checker

// >>> src/region_mode_decide.v
// Purpose: Decision table for a program command against a region state.
// Assumes: Purely combinational, inputs stable for one cycle.
// Notes: Zero error mask means the program may proceed.
`include "flash_cmd_map.vh"
module region_mode_decide (
    input wire i_single,
    input wire i_upper,
    input wire [1:0] i_state,
    output reg [`STATUS_W-1:0] o_err,
    output reg [1:0] o_new_state
);
    always @* begin
        o_err = {`STATUS_W{1'b0}};
        o_new_state = i_state;
        case (i_state)
            `RGN_ERASED: begin
                if (i_single && i_upper) begin
                    o_err = `MASK_OR | `MASK_CV;
                end else if (i_upper) begin
                    o_new_state = `RGN_OBJECT;
                end else begin
                    o_new_state = `RGN_CONTROL;
                end
            end
            `RGN_CONTROL: begin
                if (i_upper) begin
                    o_err = i_single ? (`MASK_PE | `MASK_OR | `MASK_CV) : (`MASK_PE | `MASK_CV);
                end
            end
            default: begin
                o_err = `MASK_PE | `MASK_OR;
            end
        endcase
    end
endmodule // region_mode_decide

// >>> src/region_state_ram.v
// Purpose: Per-region programming mode store, one entry per region.
// Assumes: One write and one registered read per cycle.
// Notes: Contents undefined until the owner sweeps it after reset.
module region_state_ram #(
    parameter AW = 14
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_we,
    input wire [AW-1:0] i_waddr,
    input wire [1:0] i_wdata,
    input wire [AW-1:0] i_raddr,
    output reg [1:0] o_rdata
);
    reg [1:0] mem [0:(1<<AW)-1];

    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 2'h0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule // region_state_ram

// >>> testbench/bus_host.sv
// Purpose: Host side bus master for the register slave.
// Assumes: Slave answers with waitrequest low.
// Notes: Waits without limit; the bench timeout ends a hang.
module bus_host (
    input wire i_clk,
    input wire i_waitrequest,
    input wire [31:0] i_readdata,
    output logic [7:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_address, o_read, o_write, o_writedata} = '0;
    end
    task automatic bus_xfer(input logic r, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge i_clk);
        o_address <= a;
        o_writedata <= d;
        o_read <= r;
        o_write <= !r;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        q = i_readdata;
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
    task automatic flash_cmd(input logic [31:0] a, input logic [15:0] c);
        logic [31:0] q;
        bus_xfer(1'b0, 8'h00, a, q);
        bus_xfer(1'b0, 8'h04, {16'h0000, c}, q);
    endtask
endmodule // bus_host

// >>> testbench/mode_asserts.sv
// Purpose: Port checks for the program region mode checker.
// Assumes: One clock, asynchronous active low reset.
// Notes: Sees only the top module ports.
module mode_asserts (
    input wire I_CLK,
    input wire I_RST_N,
    input wire [7:0] I_AVS_ADDRESS,
    input wire I_AVS_READ,
    input wire I_AVS_WRITE,
    input wire [31:0] I_AVS_WRITEDATA,
    input wire [31:0] O_AVS_READDATA,
    input wire O_AVS_WAITREQUEST,
    input wire I_VPP_VALID,
    input wire O_DEVICE_READY
);
    timeunit 1ns;
    timeprecision 1ps;
    // Erase may hold ready low longest; bound kept loose
    localparam int BACK_MAX = 300;
    wire req;
    wire zero_rd;
    assign req = I_AVS_READ | I_AVS_WRITE;
    assign zero_rd = (I_AVS_ADDRESS[1:0] != 2'h0) || (I_AVS_ADDRESS > 8'h0C)
        || (I_AVS_ADDRESS == 8'h04);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    ////////////////////////////////////////////////////////////////////////
    property p_wait_one; req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST; endproperty
    a_wait_one: assert property (p_wait_one) else $error("request not answered");
    property p_wait_pulse; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("answer held too long");
    property p_wait_cause; !O_AVS_WAITREQUEST |-> $past(req); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_idle_hold; !req && O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("answer while idle");
    property p_zero_read;
        !O_AVS_WAITREQUEST && I_AVS_READ && zero_rd |-> O_AVS_READDATA == 32'h0;
    endproperty
    a_zero_read: assert property (p_zero_read) else $error("read data not zero");
    property p_rdata_hold; $changed(O_AVS_READDATA) |-> $past(I_AVS_READ && O_AVS_WAITREQUEST);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_ready_cause;
        $fell(O_DEVICE_READY) |-> $past(I_AVS_WRITE && !O_AVS_WAITREQUEST
            && I_AVS_ADDRESS == 8'h04);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready fell unasked");
    property p_ready_back; $fell(O_DEVICE_READY) |-> ##[1:BACK_MAX] O_DEVICE_READY; endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready stuck low");
    c_busy: cover property ($fell(O_DEVICE_READY));
    c_zero: cover property (!O_AVS_WAITREQUEST && I_AVS_READ && zero_rd);
    c_done: cover property ($rose(O_DEVICE_READY));
endmodule // mode_asserts

// >>> testbench/test_program_region_mode_checker.sv
// Purpose: Self-checking bench for the program region mode checker.
// Assumes: Short sweep and program counts set by parameters.
// Notes: Each program step clears status afterwards.
module test_program_region_mode_checker;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vpp = 1'b1;
    logic [7:0] address;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic waitreq;
    logic ready;
    logic [31:0] q;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    program_region_mode_checker #(.BLOCK_BITS(3), .PROG_CYCLES(40)) program_region_mode_checker_i (
        .I_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(address), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_VPP_VALID(vpp), .O_DEVICE_READY(ready));
    bus_host bus_host_i (.i_clk(clk), .i_waitrequest(waitreq), .i_readdata(rdata),
        .o_address(address), .o_read(rd), .o_write(wr), .o_writedata(wdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        compares++;
        if ((got & m) !== (exp & m)) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xf(input logic r, input logic [7:0] a, input logic [31:0] d);
        bus_host_i.bus_xfer(r, a, d, q);
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        while (ready !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, ready}, 32'h1, 32'h1);
    endtask
    task automatic step(input logic [31:0] a, input logic [15:0] c, input logic [15:0] d,
        input logic v, input logic [9:0] e);
        vpp <= v;
        bus_host_i.flash_cmd(a, c);
        bus_host_i.flash_cmd(a, d);
        wait_ready();
        xf(1'b1, 8'h08, 32'h0);
        chk(q, {22'h0, e} | 32'h80, 32'h3BA);
        xf(1'b0, 8'h08, 32'h0);
        vpp <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wait_ready();
        xf(1'b1, 8'h08, 32'h0);
        chk(q, 32'h80, 32'h3FA);
        xf(1'b1, 8'h0C, 32'h0);
        chk(q, 32'h4, 32'hF);
        xf(1'b0, 8'h00, 32'hFFF1_2345);
        xf(1'b1, 8'h00, 32'h0);
        chk(q, 32'h1_2345, 32'hF_FFFF);
        xf(1'b0, 8'h10, 32'h1);
        xf(1'b1, 8'h10, 32'h0);
        chk(q, 32'h0, 32'hFFFF_FFFF);
        xf(1'b1, 8'h04, 32'h0);
        chk(q, 32'h0, 32'hFFFF_FFFF);
        $display("test registers done");
        step(32'h200, 16'h0041, 16'h0000, 1'b1, 10'h000);
        step(32'h200, 16'h00E9, 16'h00D0, 1'b1, 10'h000);
        step(32'h200, 16'h0080, 16'h00D0, 1'b1, 10'h000);
        step(32'h208, 16'h00E9, 16'h00D0, 1'b1, 10'h210);
        step(32'h208, 16'h0041, 16'h0000, 1'b1, 10'h310);
        step(32'h200, 16'h0041, 16'h0000, 1'b1, 10'h000);
        step(32'h408, 16'h0041, 16'h0000, 1'b1, 10'h300);
        step(32'h408, 16'h00E9, 16'h00D0, 1'b1, 10'h000);
        step(32'h400, 16'h00E9, 16'h00D0, 1'b1, 10'h110);
        step(32'h400, 16'h0041, 16'h0000, 1'b1, 10'h110);
        step(32'h608, 16'h0080, 16'h00D0, 1'b1, 10'h000);
        step(32'h608, 16'h0080, 16'h00D0, 1'b1, 10'h110);
        step(32'hE00, 16'h0041, 16'hFFFF, 1'b1, 10'h000);
        step(32'hE08, 16'h00E9, 16'h00D0, 1'b1, 10'h000);
        step(32'h800, 16'h00E9, 16'h1234, 1'b1, 10'h030);
        step(32'h800, 16'h0041, 16'h0000, 1'b0, 10'h018);
        step(32'h2_0000, 16'h0060, 16'h0001, 1'b1, 10'h000);
        step(32'h2_0000, 16'h0041, 16'h0000, 1'b1, 10'h012);
        $display("test regions done");
        vpp <= 1'b0;
        bus_host_i.flash_cmd(32'h0, 16'h0098);
        xf(1'b1, 8'h0C, 32'h0);
        chk(q, 32'h3, 32'h3);
        vpp <= 1'b1;
        bus_host_i.flash_cmd(32'hA00, 16'h0041);
        xf(1'b1, 8'h0C, 32'h0);
        chk(q, 32'h1, 32'h3);
        bus_host_i.flash_cmd(32'hA00, 16'h0000);
        bus_host_i.flash_cmd(32'hA00, 16'h0098);
        chk({31'h0, ready}, 32'h0, 32'h1);
        xf(1'b1, 8'h0C, 32'h0);
        chk(q, 32'h3, 32'h7);
        wait_ready();
        xf(1'b1, 8'h0C, 32'h0);
        chk(q, 32'h7, 32'h7);
        bus_host_i.flash_cmd(32'hA00, 16'h0090);
        xf(1'b1, 8'h0C, 32'h0);
        chk(q, 32'h6, 32'h7);
        $display("test cfi done");
        bus_host_i.flash_cmd(32'h0, 16'h0020);
        bus_host_i.flash_cmd(32'h0, 16'h00D0);
        bus_host_i.flash_cmd(32'h0, 16'h00B0);
        xf(1'b1, 8'h08, 32'h0);
        chk(q, 32'hC0, 32'hC0);
        step(32'h4_0000, 16'h0041, 16'h0000, 1'b1, 10'h000);
        bus_host_i.flash_cmd(32'h0, 16'h00D0);
        wait_ready();
        step(32'h208, 16'h00E9, 16'h00D0, 1'b1, 10'h000);
        step(32'h400, 16'h0041, 16'h0000, 1'b1, 10'h000);
        $display("test erase done");
        give_verdict();
    end
endmodule // test_program_region_mode_checker
bind program_region_mode_checker mode_asserts mode_asserts_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_VPP_VALID(I_VPP_VALID),
    .O_DEVICE_READY(O_DEVICE_READY));
